// file: design/ncw_pkg.sv
/*
  Constants, field layouts and types for the waveform oscillator core.
  Assumes a single 200 MHz clock and control words handed in whole, 16 bits at a time.
*/
package ncw_pkg;

  // ----------------------------------------
  // Word address field and phase-word select bit
  // ----------------------------------------
  localparam int ADDR_HI = 15;
  localparam int ADDR_LO = 14;
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_FREQ_A = 2'h1;
  localparam logic [1:0] ADDR_FREQ_B = 2'h2;
  localparam logic [1:0] ADDR_PHASE = 2'h3;
  localparam int PHASE_SEL_BIT = 13;

  // ----------------------------------------
  // Control bit positions
  // ----------------------------------------
  localparam int CTL_FULL_WORD = 13;
  localparam int CTL_HIGH_HALF = 12;
  localparam int CTL_FREQ_SEL = 11;
  localparam int CTL_PHASE_SEL = 10;
  localparam int CTL_RESET = 8;
  localparam int CTL_CLOCK_HALT = 7;
  localparam int CTL_DAC_POWERDOWN = 6;
  localparam int CTL_SQUARE_SEL = 5;
  localparam int CTL_HALF_RATE = 3;
  localparam int CTL_MODE = 1;

  // ----------------------------------------
  // Widths, reset values and timing
  // ----------------------------------------
  localparam int FREQ_W = 28;
  localparam int HALF_W = 14;
  localparam int PHASE_W = 12;
  localparam int CODE_W = 10;
  localparam logic [13:0] CTRL_RESET_VAL = 14'h0000;
  localparam logic [27:0] FREQ_RESET_VAL = 28'h0000000;
  localparam logic [11:0] PHASE_RESET_VAL = 12'h000;
  localparam logic [9:0] CODE_MIDSCALE = 10'h200;
  localparam int LATENCY_CYCLES = 7;
  localparam int FRONT_STAGES = 3;

  // One output sample moving down the delay line
  typedef struct packed {
    logic [9:0] code;
    logic msb;
  } ncw_sample_s;

endpackage

// file: design/ncw_core.sv
/*
  Oscillator core: word decode, tuning and offset storage, phase accumulator,
  waveform shaping and output delay line.
  Assumes words arrive already deserialised with a one-cycle strobe, synchronous
  to clock; the analog DAC sits outside and reads waveCode.
*/
`timescale 1ns/1ps
`default_nettype none

module ncw_core #(
  parameter int LATENCY = ncw_pkg::LATENCY_CYCLES
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [15:0] wordData,
  input wire logic wordValid,
  output logic [ncw_pkg::CODE_W-1:0] waveCode,
  output logic waveIsSquare,
  output logic squareLevel,
  output logic dacPowerdown
);
  import ncw_pkg::*;

  // Delay line needs at least one stage beyond the front pipeline
  if (LATENCY <= FRONT_STAGES) begin : gBadLatency
    $error("ncw_core: LATENCY must exceed FRONT_STAGES");
  end
  localparam int TAIL = LATENCY - FRONT_STAGES;

  // ----------------------------------------
  // Stored words
  // ----------------------------------------
  logic [13:0] ctrl_r, ctrl_nxt;
  logic [FREQ_W-1:0] freqA_r, freqA_nxt, freqB_r, freqB_nxt;
  logic [PHASE_W-1:0] phaseA_r, phaseA_nxt, phaseB_r, phaseB_nxt;
  logic [HALF_W-1:0] lowHold_r, lowHold_nxt;
  logic lowPendA_r, lowPendA_nxt, lowPendB_r, lowPendB_nxt;
  logic [1:0] addr;
  logic [HALF_W-1:0] payload;

  assign addr = wordData[ADDR_HI:ADDR_LO];
  assign payload = wordData[HALF_W-1:0];

  // Word decode; full-word mode holds low half until the high half lands
  // so the tuning word never carries an intermediate value
  always_comb begin
    ctrl_nxt = ctrl_r;
    freqA_nxt = freqA_r;
    freqB_nxt = freqB_r;
    phaseA_nxt = phaseA_r;
    phaseB_nxt = phaseB_r;
    lowHold_nxt = lowHold_r;
    lowPendA_nxt = lowPendA_r;
    lowPendB_nxt = lowPendB_r;
    if (wordValid) begin
      case (addr)
        ADDR_CTRL: begin
          ctrl_nxt = payload;
          lowPendA_nxt = 1'b0;
          lowPendB_nxt = 1'b0;
        end
        ADDR_FREQ_A: begin
          if (ctrl_r[CTL_FULL_WORD]) begin
            if (lowPendA_r) begin
              freqA_nxt = {payload, lowHold_r};
              lowPendA_nxt = 1'b0;
            end else begin
              lowHold_nxt = payload;
              lowPendA_nxt = 1'b1;
              lowPendB_nxt = 1'b0;
            end
          end else if (ctrl_r[CTL_HIGH_HALF]) begin
            freqA_nxt = {payload, freqA_r[HALF_W-1:0]};
          end else begin
            freqA_nxt = {freqA_r[FREQ_W-1:HALF_W], payload};
          end
        end
        ADDR_FREQ_B: begin
          if (ctrl_r[CTL_FULL_WORD]) begin
            if (lowPendB_r) begin
              freqB_nxt = {payload, lowHold_r};
              lowPendB_nxt = 1'b0;
            end else begin
              lowHold_nxt = payload;
              lowPendB_nxt = 1'b1;
              lowPendA_nxt = 1'b0;
            end
          end else if (ctrl_r[CTL_HIGH_HALF]) begin
            freqB_nxt = {payload, freqB_r[HALF_W-1:0]};
          end else begin
            freqB_nxt = {freqB_r[FREQ_W-1:HALF_W], payload};
          end
        end
        ADDR_PHASE: begin
          if (wordData[PHASE_SEL_BIT]) begin
            phaseB_nxt = wordData[PHASE_W-1:0];
          end else begin
            phaseA_nxt = wordData[PHASE_W-1:0];
          end
        end
        default: begin
          ctrl_nxt = ctrl_r;
        end
      endcase
    end
  end

  // Word storage; sync reset keeps the part in a known idle state
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ctrl_r <= CTRL_RESET_VAL;
      freqA_r <= FREQ_RESET_VAL;
      freqB_r <= FREQ_RESET_VAL;
      phaseA_r <= PHASE_RESET_VAL;
      phaseB_r <= PHASE_RESET_VAL;
      lowHold_r <= '0;
      lowPendA_r <= 1'b0;
      lowPendB_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      freqA_r <= freqA_nxt;
      freqB_r <= freqB_nxt;
      phaseA_r <= phaseA_nxt;
      phaseB_r <= phaseB_nxt;
      lowHold_r <= lowHold_nxt;
      lowPendA_r <= lowPendA_nxt;
      lowPendB_r <= lowPendB_nxt;
    end
  end

  // ----------------------------------------
  // Phase path
  // ----------------------------------------
  logic halt, clear;
  logic [FREQ_W-1:0] step_r, step_nxt, acc_r, acc_nxt;
  logic [PHASE_W-1:0] offPick_r, offPick_nxt, offset_r, offset_nxt, phase_r, phase_nxt;

  assign halt = ctrl_r[CTL_CLOCK_HALT];
  assign clear = ctrl_r[CTL_RESET];

  // Halt freezes the whole datapath so the output holds its value
  always_comb begin
    step_nxt = step_r;
    offPick_nxt = offPick_r;
    offset_nxt = offset_r;
    acc_nxt = acc_r;
    phase_nxt = phase_r;
    if (!halt) begin
      step_nxt = ctrl_r[CTL_FREQ_SEL] ? freqB_r : freqA_r;
      // Offset takes one extra stage so a phase load lands as late as a tuning load
      offPick_nxt = ctrl_r[CTL_PHASE_SEL] ? phaseB_r : phaseA_r;
      offset_nxt = offPick_r;
      if (clear) begin
        acc_nxt = '0;
        phase_nxt = '0;
      end else begin
        acc_nxt = acc_r + step_r;
        // Wraps naturally at 12 bits: 4096 steps per full turn
        phase_nxt = acc_r[FREQ_W-1 -: PHASE_W] + offset_r;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      step_r <= FREQ_RESET_VAL;
      offPick_r <= PHASE_RESET_VAL;
      offset_r <= PHASE_RESET_VAL;
      acc_r <= FREQ_RESET_VAL;
      phase_r <= PHASE_RESET_VAL;
    end else begin
      step_r <= step_nxt;
      offPick_r <= offPick_nxt;
      offset_r <= offset_nxt;
      acc_r <= acc_nxt;
      phase_r <= phase_nxt;
    end
  end

  // ----------------------------------------
  // Shaping
  // ----------------------------------------
  // Parabolic sine approximation stands in for a ROM table: cheaper in
  // flops, at the cost of a few percent harmonic error
  function automatic logic [9:0] sineLookup(input logic [11:0] p);
    logic [10:0] x;
    logic [21:0] prod;
    logic [9:0] amp;
    x = p[10:0];
    prod = 22'(x) * 22'(12'h800 - {1'b0, x});
    amp = (prod[21:11] > 11'h1FF) ? 10'h1FF : prod[20:11];
    sineLookup = p[11] ? (CODE_MIDSCALE - amp) : (CODE_MIDSCALE + amp);
  endfunction

  ncw_sample_s shaped;
  always_comb begin
    shaped.msb = phase_r[PHASE_W-1];
    if (ctrl_r[CTL_MODE]) begin
      shaped.code = phase_r[11] ? ~phase_r[10:1] : phase_r[10:1];
    end else begin
      shaped.code = sineLookup(phase_r);
    end
  end

  // ----------------------------------------
  // Delay line and output stage
  // ----------------------------------------
  ncw_sample_s line_r [TAIL], line_nxt [TAIL];
  logic msbPrev_r, msbPrev_nxt, halfSq_r, halfSq_nxt;
  logic square_r, square_nxt, isSq_r, isSq_nxt, pd_r, pd_nxt;

  // Fill the line with midscale while cleared so the output settles there
  for (genvar i = 0; i < TAIL; i++) begin : gLine
    // Head and body split at elaboration so no stage indexes below zero
    if (i == 0) begin : gHead
      always_comb begin
        line_nxt[i] = line_r[i];
        if (!halt) begin
          line_nxt[i] = clear ? ncw_sample_s'{code: CODE_MIDSCALE, msb: 1'b0} : shaped;
        end
      end
    end else begin : gBody
      always_comb begin
        line_nxt[i] = line_r[i];
        if (!halt) begin
          line_nxt[i] = line_r[i-1];
        end
      end
    end
    always_ff @(posedge clock) begin
      if (!rst_b) begin
        line_r[i] <= '{code: CODE_MIDSCALE, msb: 1'b0};
      end else begin
        line_r[i] <= line_nxt[i];
      end
    end
  end

  // Square output: MSB direct or toggled on each MSB rise (half rate)
  always_comb begin
    msbPrev_nxt = msbPrev_r;
    halfSq_nxt = halfSq_r;
    if (!halt) begin
      msbPrev_nxt = line_r[TAIL-1].msb;
      if (line_r[TAIL-1].msb && !msbPrev_r) begin
        halfSq_nxt = ~halfSq_r;
      end
    end
    square_nxt = ctrl_r[CTL_HALF_RATE] ? line_r[TAIL-1].msb : halfSq_r;
    isSq_nxt = ctrl_r[CTL_SQUARE_SEL];
    pd_nxt = ctrl_r[CTL_DAC_POWERDOWN];
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      msbPrev_r <= 1'b0;
      halfSq_r <= 1'b0;
      square_r <= 1'b0;
      isSq_r <= 1'b0;
      pd_r <= 1'b0;
    end else begin
      msbPrev_r <= msbPrev_nxt;
      halfSq_r <= halfSq_nxt;
      square_r <= square_nxt;
      isSq_r <= isSq_nxt;
      pd_r <= pd_nxt;
    end
  end

  // Output pins: waveCode always carries the DAC code; square level and its select flag have their own pins
  assign waveCode = line_r[TAIL-1].code;
  assign waveIsSquare = isSq_r;
  assign squareLevel = square_r;
  assign dacPowerdown = pd_r;

endmodule

`default_nettype wire

// file: verif/ncw_core_assertions.sv
/* Port checker for the oscillator core.
   Assumes it is bound onto ncw_core with a free-running clock. */
`timescale 1ns/1ps
`default_nettype none
module ncw_core_assertions (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [15:0] wordData,
  input wire logic wordValid,
  input wire logic [ncw_pkg::CODE_W-1:0] waveCode,
  input wire logic waveIsSquare,
  input wire logic squareLevel,
  input wire logic dacPowerdown
);
  import ncw_pkg::*;
  default clocking cb @(posedge clock); endclocking
  // Control word taken at this edge
  wire logic ctlWr = wordValid && (wordData[ADDR_HI:ADDR_LO] == ADDR_CTRL);
  // Register-copy outputs follow their control bit two edges on
  property p_pd;
    disable iff (!rst_b) ctlWr |-> ##2 dacPowerdown == $past(wordData[CTL_DAC_POWERDOWN], 2);
  endproperty
  a_pd: assert property (p_pd) else $error("powerdown copy wrong");
  property p_sq;
    disable iff (!rst_b) ctlWr |-> ##2 waveIsSquare == $past(wordData[CTL_SQUARE_SEL], 2);
  endproperty
  a_sq: assert property (p_sq) else $error("square select copy wrong");
  // Held reset bit drains the line to midscale; halt excluded since it freezes the line
  property p_mid;
    disable iff (!rst_b) (ctlWr && wordData[CTL_RESET] && !wordData[CTL_CLOCK_HALT])
      ##1 !ctlWr [*8] |-> ##2 waveCode == CODE_MIDSCALE;
  endproperty
  a_mid: assert property (p_mid) else $error("reset bit gave no midscale");
  property p_midsq;
    disable iff (!rst_b) (ctlWr && wordData[CTL_RESET] && !wordData[CTL_CLOCK_HALT])
      ##1 !ctlWr [*8] |-> ##2 $stable(squareLevel);
  endproperty
  a_midsq: assert property (p_midsq) else $error("square moved in reset");
  property p_halt;
    disable iff (!rst_b) (ctlWr && wordData[CTL_CLOCK_HALT]) ##1 !ctlWr [*4]
      |-> $stable(waveCode) && $stable(squareLevel);
  endproperty
  a_halt: assert property (p_halt) else $error("output moved while halted");
  property p_non;
    disable iff (!rst_b) (wordValid && wordData[ADDR_HI:ADDR_LO] != ADDR_CTRL)
      |-> ##2 $stable(dacPowerdown) && $stable(waveIsSquare);
  endproperty
  a_non: assert property (p_non) else $error("data word changed control");
  property p_rcode;
    !rst_b |=> waveCode == CODE_MIDSCALE;
  endproperty
  a_rcode: assert property (p_rcode) else $error("reset code not midscale");
  property p_rctl;
    !rst_b |=> !dacPowerdown && !waveIsSquare;
  endproperty
  a_rctl: assert property (p_rctl) else $error("reset control not clear");
endmodule
bind ncw_core ncw_core_assertions u_chk (.clock(clock), .rst_b(rst_b), .wordData(wordData),
  .wordValid(wordValid), .waveCode(waveCode), .waveIsSquare(waveIsSquare),
  .squareLevel(squareLevel), .dacPowerdown(dacPowerdown));
`default_nettype wire

// file: verif/ncw_host.sv
/* Host model that hands whole 16-bit words to the core.
   Assumes the caller runs send from one process only. */
`timescale 1ns/1ps
`default_nettype none
module ncw_host (
  input wire logic clock,
  output logic [15:0] wordData,
  output logic wordValid
);
  initial begin
    wordData = 16'h0000;
    wordValid = 1'b0;
  end
  // One word per call, launched off the falling edge
  task automatic send(input logic [15:0] w);
    logic [15:0] v;
    v = w;
    if (v[15:14] == 2'h0) begin
      v = v & 16'hFDEA;
      if (v[5]) v[1] = 1'b0;
    end
    @(negedge clock);
    wordData = v;
    wordValid = 1'b1;
    @(negedge clock);
    wordValid = 1'b0;
    wordData = ~v; // Idle bus must not look like the last word
  endtask
endmodule
`default_nettype wire

// file: verif/ncw_core_tb_top.sv
/* Self-checking bench for the oscillator core.
   Assumes the host model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module ncw_core_tb_top;
  import ncw_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] wordData;
  logic wordValid;
  logic [CODE_W-1:0] waveCode;
  logic waveIsSquare, squareLevel, dacPowerdown;
  int badCount = 0;
  int totalChecks = 0;
  int cycles = 0;
  always #2.5 clock = ~clock;
  ncw_host host (.clock(clock), .wordData(wordData), .wordValid(wordValid));
  ncw_core dut (.clock(clock), .rst_b(rst_b), .wordData(wordData), .wordValid(wordValid),
    .waveCode(waveCode), .waveIsSquare(waveIsSquare), .squareLevel(squareLevel),
    .dacPowerdown(dacPowerdown));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      badCount++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic endOfTest();
    if (badCount == 0 && totalChecks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Hang guard, far above the roughly 450 cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      badCount++;
      endOfTest();
    end
  end
  task automatic t_reset();
    chk(16'(waveCode), 16'h0200);
    chk(16'(dacPowerdown), 16'h0);
    chk(16'(waveIsSquare), 16'h0);
  endtask
  // Word builders: address field from one place, payload from the caller
  task automatic ctl(input logic [13:0] bits);
    host.send({ADDR_CTRL, bits});
  endtask
  task automatic frq(input logic b, input logic [13:0] half);
    host.send({b ? ADDR_FREQ_B : ADDR_FREQ_A, half});
  endtask
  task automatic phs(input logic b, input logic [11:0] val);
    host.send({ADDR_PHASE, b, 1'b0, val});
  endtask
  task automatic t_ctrl();
    for (int i = 0; i < 4; i++) begin
      ctl(14'(i) << CTL_SQUARE_SEL);
      cyc(2);
      chk(16'(dacPowerdown), 16'(i[1]));
      chk(16'(waveIsSquare), 16'(i[0]));
    end
  endtask
  // Steps of 2^17 and 2^18 give triangle slopes of 1 and 2 codes a cycle
  task automatic t_tri();
    logic [9:0] a;
    ctl(14'h1102);
    frq(1'b0, 14'h0008);
    frq(1'b1, 14'h0010);
    cyc(12);
    chk(16'(waveCode), 16'h0200);
    ctl(14'h1002);
    cyc(12);
    a = waveCode;
    cyc(1);
    chk(16'(10'(waveCode - a)), 16'h0001);
    ctl(14'h1802);
    cyc(10);
    a = waveCode;
    cyc(1);
    chk(16'(10'(waveCode - a)), 16'h0002);
    // Low half adds 2^13 to A: 16 cycles move 34 phase steps, so 17 codes
    ctl(14'h0002);
    frq(1'b0, 14'h2000);
    cyc(10);
    a = waveCode;
    cyc(16);
    chk(16'(10'(waveCode - a)), 16'h0011);
  endtask
  // Paired full-word load zeroes the step, so the code is the offset alone
  task automatic t_phase();
    ctl(14'h2102);
    frq(1'b0, 14'h0000);
    frq(1'b0, 14'h0000);
    phs(1'b0, 12'h9A0);
    phs(1'b1, 12'h0C6);
    ctl(14'h1002);
    cyc(10);
    chk(16'(waveCode), 16'h032F);
    ctl(14'h1402);
    cyc(10);
    chk(16'(waveCode), 16'h0063);
    // Sine peaks at a quarter turn and bottoms out at three quarters
    phs(1'b0, 12'h400);
    phs(1'b1, 12'hC00);
    ctl(14'h0000);
    cyc(10);
    chk(16'(waveCode), 16'h03FF);
    ctl(14'h0400);
    cyc(10);
    chk(16'(waveCode), 16'h0001);
  endtask
  task automatic togg(output int n);
    logic p;
    n = 0;
    p = squareLevel;
    repeat (64) begin
      cyc(1);
      if (squareLevel !== p) n++;
      p = squareLevel;
    end
  endtask
  // Step 2^24 flips the phase top bit every 8 cycles
  task automatic t_square();
    int n;
    ctl(14'h1028);
    frq(1'b0, 14'h0400);
    cyc(10);
    togg(n);
    chk(16'(n), 16'h0008);
    chk(16'(waveIsSquare), 16'h1);
    ctl(14'h1020);
    cyc(40);
    togg(n);
    chk(16'(n), 16'h0004);
  endtask
  // Halt freezes code and square; clearing it must restart the divider
  task automatic t_halt();
    logic [9:0] a;
    logic s;
    int n;
    ctl(14'h1082);
    cyc(6);
    a = waveCode;
    s = squareLevel;
    cyc(20);
    chk(16'(waveCode), 16'(a));
    chk(16'(squareLevel), 16'(s));
    ctl(14'h1002);
    cyc(10);
    togg(n);
    chk(16'(n), 16'h0004);
  endtask
  initial begin
    cyc(12);
    rst_b = 1'b1;
    t_reset();
    t_ctrl();
    t_tri();
    t_phase();
    t_square();
    t_halt();
    endOfTest();
  end
endmodule
`default_nettype wire
